/* lcd_cmd_pkg.sv */
package lcd_cmd_pkg;
  // command codes
  localparam logic [7:0] CMD_DISPLAY_OFF = 8'h28;
  localparam logic [7:0] CMD_DISPLAY_ON = 8'h29;
  localparam logic [7:0] CMD_COLUMN_WINDOW_SET = 8'h2A;
  localparam logic [7:0] CMD_PAGE_WINDOW_SET = 8'h2B;
  localparam logic [7:0] CMD_MEMORY_WRITE = 8'h2C;
  localparam logic [7:0] CMD_COLOUR_LUT_LOAD = 8'h2D;
  localparam logic [7:0] CMD_RAM_READ = 8'h2E;
  localparam logic [7:0] CMD_MEMORY_ACCESS_CONTROL = 8'h36;
  // reset window bounds
  localparam logic [7:0] START_COLUMN_RESET = 8'h00;
  localparam logic [7:0] END_COLUMN_RESET_FULL = 8'h67;
  localparam logic [7:0] END_COLUMN_RESET_DIV = 8'h61;
  localparam logic [7:0] START_PAGE_RESET = 8'h00;
  localparam logic [7:0] END_PAGE_RESET_FULL = 8'h53;
  localparam logic [7:0] END_PAGE_RESET_DIV = 8'h42;
  // physical ram size
  localparam int RAM_COLUMNS = 104;
  localparam int RAM_PAGES = 84;
  // lut layout: 8 red, 8 green, 4 blue
  localparam logic [4:0] LUT_ENTRIES = 5'h14;
  localparam logic [4:0] LUT_GREEN_BASE = 5'h08;
  localparam logic [4:0] LUT_BLUE_BASE = 5'h10;
  // memory access control direction bit position
  localparam int MAC_PAGE_DIR_BIT = 5;
  localparam logic [7:0] MAC_RESET = 8'h00;

  // host byte as it arrives
  typedef struct packed {
    logic is_data;
    logic [7:0] value;
  } host_byte_type;

  // pixel word leaving toward the ram
  typedef struct packed {
    logic [7:0] column;
    logic [7:0] page;
    logic [11:0] colour;
  } pixel_word_type;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_COL_PARAM = 6'h02,
    ST_PAGE_PARAM = 6'h04,
    ST_WRITE = 6'h08,
    ST_LUT = 6'h10,
    ST_READ = 6'h20
  } mode_type;
endpackage

/* pixel_skid_buffer.sv */
`timescale 1ns/1ps
// two-entry buffer; upstream ready is registered so a stall never drops a word
module pixel_skid_buffer #(
  parameter int WIDTH = 28
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  logic [WIDTH-1:0] slot0_q;
  logic [WIDTH-1:0] slot1_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign in_ready = (count_q != 2'h2);
  assign out_valid = (count_q != 2'h0);
  assign out_data = slot0_q;

  // occupancy
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      count_q <= 2'h0;
    end else if (push && !pop) begin
      count_q <= count_q + 2'h1;
    end else if (pop && !push) begin
      count_q <= count_q - 2'h1;
    end
  end

  // head slot shifts forward on pop
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      slot0_q <= '0;
      slot1_q <= '0;
    end else begin
      if (pop) begin
        slot0_q <= (count_q == 2'h2) ? slot1_q : in_data;
      end else if (push && count_q == 2'h0) begin
        slot0_q <= in_data;
      end
      if (push && ((count_q == 2'h1 && !pop) || (count_q == 2'h2))) begin
        slot1_q <= in_data;
      end
    end
  end
endmodule

/* lcd_ram_window_commands.sv */
`timescale 1ns/1ps
module lcd_ram_window_commands (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic ram_division_strap,
  input wire lcd_cmd_pkg::host_byte_type host_byte,
  input wire logic host_valid,
  output logic host_ready,
  input wire logic colour_256_mode,
  output logic display_on,
  output logic segments_off,
  output lcd_cmd_pkg::pixel_word_type pixel_word,
  output logic pixel_valid,
  input wire logic pixel_ready,
  output logic [7:0] read_column,
  output logic [7:0] read_page,
  output logic read_request,
  output logic read_in_range,
  output logic [7:0] start_column,
  output logic [7:0] end_column,
  output logic [7:0] start_page,
  output logic [7:0] end_page,
  output logic page_direction
);
  import lcd_cmd_pkg::*;

  // decoder and display state
  mode_type mode_q;
  logic display_on_q;

  // write window bounds and address counters
  logic [7:0] start_column_q;
  logic [7:0] end_column_q;
  logic [7:0] start_page_q;
  logic [7:0] end_page_q;
  logic [7:0] column_q;
  logic [7:0] page_q;

  // parameter phase, access control and lut
  logic second_param_q;
  logic mac_pending_q;
  logic [7:0] mac_q;
  logic [4:0] lut_index_q;
  logic [3:0] lut_q [0:19];

  // strap capture and ram read strobe
  logic strap_taken_q;
  logic read_request_q;
  logic read_in_range_q;
  logic [7:0] read_column_q;
  logic [7:0] read_page_q;

  // buffer hookup and decoded strobes
  logic buf_in_ready;
  logic buf_in_valid;
  pixel_word_type buf_in_data;
  pixel_word_type buf_out_data;
  logic buf_out_valid;
  logic take;
  logic is_cmd;
  logic is_data;
  logic in_range;
  logic [11:0] colour;
  logic advance;

  // in write mode every byte waits for buffer room, a command as well;
  // keeps ready off the select bit, at the cost of a later exit from a stalled write
  assign host_ready = (mode_q != ST_WRITE) || buf_in_ready;
  assign take = host_valid && host_ready;
  assign is_cmd = take && !host_byte.is_data;
  assign is_data = take && host_byte.is_data;
  assign in_range = (column_q < 8'(RAM_COLUMNS)) && (page_q < 8'(RAM_PAGES));
  assign advance = (is_data && (mode_q == ST_WRITE || mode_q == ST_READ));

  // palette translation; upper lut bits never stored so only low nibble matters
  always_comb begin
    if (colour_256_mode) begin
      colour = {lut_q[{2'h0, host_byte.value[7:5]}],
                lut_q[LUT_GREEN_BASE + {2'h0, host_byte.value[4:2]}],
                lut_q[LUT_BLUE_BASE + {3'h0, host_byte.value[1:0]}]};
    end else begin
      colour = {4'h0, host_byte.value}; // direct byte when not in 256-colour mode
    end
  end

  // out-of-range writes never enter the buffer
  assign buf_in_valid = is_data && (mode_q == ST_WRITE) && in_range;
  assign buf_in_data = '{column: column_q, page: page_q, colour: colour};

  pixel_skid_buffer #(
    .WIDTH($bits(pixel_word_type))
  ) u_buffer (
    .clk_sys(clk_sys),
    .reset(reset),
    .in_data(buf_in_data),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .out_data(buf_out_data),
    .out_valid(buf_out_valid),
    .out_ready(pixel_ready)
  );

  // command decoder; any command byte ends write, read and parameter phases
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mode_q <= ST_IDLE;
    end else if (is_cmd) begin
      case (host_byte.value)
        CMD_COLUMN_WINDOW_SET: mode_q <= ST_COL_PARAM;
        CMD_PAGE_WINDOW_SET: mode_q <= ST_PAGE_PARAM;
        CMD_MEMORY_WRITE: mode_q <= ST_WRITE;
        CMD_COLOUR_LUT_LOAD: mode_q <= ST_LUT;
        CMD_RAM_READ: mode_q <= ST_READ;
        default: mode_q <= ST_IDLE;
      endcase
    end else if (is_data) begin
      case (mode_q)
        ST_COL_PARAM, ST_PAGE_PARAM: begin
          if (second_param_q) begin
            mode_q <= ST_IDLE;
          end
        end
        ST_LUT: begin
          if (lut_index_q == LUT_ENTRIES - 5'h1) begin
            mode_q <= ST_IDLE;
          end
        end
        default: mode_q <= mode_q;
      endcase
    end
  end

  // display on/off; off after reset, only the on code leaves it
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      display_on_q <= 1'b0;
    end else if (is_cmd && host_byte.value == CMD_DISPLAY_OFF) begin
      display_on_q <= 1'b0;
    end else if (is_cmd && host_byte.value == CMD_DISPLAY_ON) begin
      display_on_q <= 1'b1;
    end
  end

  // strap caught by a clocked process after release, never under reset
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      strap_taken_q <= 1'b0;
    end else begin
      strap_taken_q <= 1'b1;
    end
  end

  // parameter phase tracker for the two-byte window commands
  always_ff @(posedge clk_sys) begin
    if (reset || is_cmd) begin
      second_param_q <= 1'b0;
    end else if (is_data && (mode_q == ST_COL_PARAM || mode_q == ST_PAGE_PARAM)) begin
      second_param_q <= !second_param_q;
    end
  end

  // window bounds; defaults follow the ram-division strap
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      start_column_q <= START_COLUMN_RESET;
      end_column_q <= END_COLUMN_RESET_FULL;
      start_page_q <= START_PAGE_RESET;
      end_page_q <= END_PAGE_RESET_FULL;
    end else if (!strap_taken_q) begin
      start_column_q <= START_COLUMN_RESET;
      end_column_q <= ram_division_strap ? END_COLUMN_RESET_DIV : END_COLUMN_RESET_FULL;
      start_page_q <= START_PAGE_RESET;
      end_page_q <= ram_division_strap ? END_PAGE_RESET_DIV : END_PAGE_RESET_FULL;
    end else if (is_data && mode_q == ST_COL_PARAM) begin
      if (!second_param_q) begin
        start_column_q <= host_byte.value;
      end else begin
        end_column_q <= host_byte.value;
      end
    end else if (is_data && mode_q == ST_PAGE_PARAM) begin
      if (!second_param_q) begin
        start_page_q <= host_byte.value;
      end else begin
        end_page_q <= host_byte.value;
      end
    end
  end

  // memory access control: one parameter byte, direction bit steers scanning
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      mac_q <= MAC_RESET;
      mac_pending_q <= 1'b0;
    end else if (is_cmd) begin
      mac_pending_q <= (host_byte.value == CMD_MEMORY_ACCESS_CONTROL);
    end else if (is_data && mac_pending_q) begin
      mac_q <= host_byte.value;
      mac_pending_q <= 1'b0;
    end
  end

  // address counters; window start loaded on write or read code
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      column_q <= START_COLUMN_RESET;
      page_q <= START_PAGE_RESET;
    end else if (is_cmd && (host_byte.value == CMD_MEMORY_WRITE || host_byte.value == CMD_RAM_READ)) begin
      column_q <= start_column_q;
      page_q <= start_page_q;
    end else if (advance) begin
      if (!mac_q[MAC_PAGE_DIR_BIT]) begin
        if (column_q == end_column_q) begin
          column_q <= start_column_q;
          page_q <= page_q + 8'h1;
        end else begin
          column_q <= column_q + 8'h1;
        end
      end else begin
        if (page_q == end_page_q) begin
          page_q <= start_page_q;
          column_q <= column_q + 8'h1;
        end else begin
          page_q <= page_q + 8'h1;
        end
      end
    end
  end

  // lut loading; contents undefined until the host fills all twenty entries
  always_ff @(posedge clk_sys) begin
    if (reset || is_cmd) begin
      lut_index_q <= 5'h00;
    end else if (is_data && mode_q == ST_LUT) begin
      lut_q[lut_index_q] <= host_byte.value[3:0];
      lut_index_q <= lut_index_q + 5'h01;
    end
  end

  // read requests to the ram; each data strobe in read mode fetches one byte
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      read_request_q <= 1'b0;
      read_in_range_q <= 1'b0;
      read_column_q <= 8'h00;
      read_page_q <= 8'h00;
    end else begin
      read_request_q <= is_data && (mode_q == ST_READ);
      if (is_data && mode_q == ST_READ) begin
        read_column_q <= column_q;
        read_page_q <= page_q;
        read_in_range_q <= in_range;
      end
    end
  end

  // registered views of state
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      display_on <= 1'b0;
      segments_off <= 1'b1;
      start_column <= START_COLUMN_RESET;
      end_column <= END_COLUMN_RESET_FULL;
      start_page <= START_PAGE_RESET;
      end_page <= END_PAGE_RESET_FULL;
      page_direction <= 1'b0;
    end else begin
      display_on <= display_on_q;
      segments_off <= !display_on_q;
      start_column <= start_column_q;
      end_column <= end_column_q;
      start_page <= start_page_q;
      end_page <= end_page_q;
      page_direction <= mac_q[MAC_PAGE_DIR_BIT];
    end
  end

  // buffer head and ram strobes; the panel scan side stops ram access on segments_off,
  // so host writes still land while the display is off
  assign pixel_word = buf_out_data;
  assign pixel_valid = buf_out_valid;
  assign read_request = read_request_q;
  assign read_in_range = read_in_range_q;
  assign read_column = read_column_q;
  assign read_page = read_page_q;
endmodule

/* lcd_ram_window_commands_props.sv */
`timescale 1ns/1ps
module lcd_ram_window_commands_props (
  input wire logic clk_sys,
  input wire logic reset,
  input wire lcd_cmd_pkg::host_byte_type host_byte,
  input wire logic host_valid,
  input wire logic host_ready,
  input wire logic display_on,
  input wire logic segments_off,
  input wire lcd_cmd_pkg::pixel_word_type pixel_word,
  input wire logic pixel_valid,
  input wire logic pixel_ready,
  input wire logic [7:0] read_column,
  input wire logic [7:0] read_page,
  input wire logic read_request,
  input wire logic read_in_range,
  input wire logic [7:0] start_column,
  input wire logic [7:0] end_column,
  input wire logic [7:0] start_page,
  input wire logic [7:0] end_page,
  input wire logic page_direction
);
  import lcd_cmd_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic tk_cmd;
  logic tk_dat;
  logic [7:0] v;
  logic on_cmd;
  logic dir_bit;
  // host byte taken at this edge, split by the select bit
  assign tk_cmd = host_valid && host_ready && !host_byte.is_data;
  assign tk_dat = host_valid && host_ready && host_byte.is_data;
  assign v = host_byte.value;
  assign on_cmd = tk_cmd && v == 8'h29;
  assign dir_bit = v[MAC_PAGE_DIR_BIT];
  // state moves at the taking edge, the registered views one edge later, so outputs show two edges on
  seg_off_a: assert property (segments_off == !display_on) else $error("segments not inverse of display");
  off_cmd_a: assert property (tk_cmd && v == 8'h28 |=> ##1 !display_on) else $error("display stayed on");
  on_cmd_a: assert property (on_cmd |=> ##1 display_on) else $error("display not turned on");
  off_stays_a: assert property (!display_on && !on_cmd && !$past(on_cmd) |=> !display_on)
    else $error("left off");
  col_win_a: assert property (tk_cmd && v == 8'h2A ##1 tk_dat ##1 tk_dat |=> ##1
    (start_column == $past(v, 3) && end_column == $past(v, 2))) else $error("column window wrong");
  page_win_a: assert property (tk_cmd && v == 8'h2B ##1 tk_dat ##1 tk_dat |=> ##1
    (start_page == $past(v, 3) && end_page == $past(v, 2))) else $error("page window wrong");
  scan_dir_a: assert property (tk_cmd && v == 8'h36 ##1 tk_dat |=> ##1 page_direction == $past(dir_bit, 2))
    else $error("direction bit not taken");
  pix_range_a: assert property (pixel_valid |-> pixel_word.column < RAM_COLUMNS && pixel_word.page < RAM_PAGES)
    else $error("pixel outside ram pushed");
  rd_range_a: assert property (read_request |->
    read_in_range == (read_column < RAM_COLUMNS && read_page < RAM_PAGES)) else $error("read range flag wrong");
  stall_hold_a: assert property (pixel_valid && !pixel_ready |=> pixel_valid && $stable(pixel_word))
    else $error("stalled pixel lost");
  rd_abort_a: assert property (tk_cmd && v != 8'h2E ##1 tk_dat |=> !read_request) else $error("read after command");
  wr_cov: cover property (tk_cmd && v == 8'h2C);
  stall_cov: cover property (pixel_valid && !pixel_ready ##1 !host_ready);
  rd_out_cov: cover property (read_request && !read_in_range);
endmodule

/* host_model.sv */
`timescale 1ns/1ps
// host side: offers one byte at a time and holds it until taken
module host_model (
  input wire logic clk_sys,
  input wire logic host_ready,
  output lcd_cmd_pkg::host_byte_type host_byte,
  output logic host_valid
);
  initial begin
    host_byte = 9'h000;
    host_valid = 1'b0;
  end
  // ready is settled by the falling edge, so it is read there for the next rising edge
  task automatic put(input logic d, input logic [7:0] val);
    logic r;
    #1;
    host_byte = {d, val};
    host_valid = 1'b1;
    do begin
      @(negedge clk_sys);
      r = host_ready;
      @(posedge clk_sys);
    end while (!r);
  endtask
  // released lines show a changed pattern, never the last byte
  task automatic idle();
    #1;
    host_valid = 1'b0;
    host_byte.value = ~host_byte.value;
  endtask
endmodule

/* lcd_ram_window_commands_tb_top.sv */
`timescale 1ns/1ps
module lcd_ram_window_commands_tb_top;
  import lcd_cmd_pkg::*;
  logic clk_sys, reset, ram_division_strap, colour_256_mode, pixel_ready;
  logic host_valid, host_ready, display_on, segments_off, pixel_valid, read_request, read_in_range, page_direction;
  host_byte_type host_byte;
  pixel_word_type pixel_word;
  logic [7:0] read_column, read_page, start_column, end_column, start_page, end_page;
  logic [3:0] lut [20];
  int n_errors = 0;
  int num_checks = 0;
  int cycles = 0;
  pixel_word_type pix_q[$];
  logic [16:0] rd_q[$];

  lcd_ram_window_commands lcd_ram_window_commands_inst (
    .clk_sys(clk_sys), .reset(reset), .ram_division_strap(ram_division_strap), .host_byte(host_byte),
    .host_valid(host_valid), .host_ready(host_ready), .colour_256_mode(colour_256_mode), .display_on(display_on),
    .segments_off(segments_off), .pixel_word(pixel_word), .pixel_valid(pixel_valid), .pixel_ready(pixel_ready),
    .read_column(read_column), .read_page(read_page), .read_request(read_request), .read_in_range(read_in_range),
    .start_column(start_column), .end_column(end_column), .start_page(start_page), .end_page(end_page),
    .page_direction(page_direction)
  );
  host_model host_model_inst (
    .clk_sys(clk_sys), .host_ready(host_ready), .host_byte(host_byte), .host_valid(host_valid)
  );

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // sink and read monitors, plus the hang guard
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (!reset && pixel_valid && pixel_ready) pix_q.push_back(pixel_word);
    if (!reset && read_request) rd_q.push_back({read_in_range, read_column, read_page});
    if (cycles == 5000) begin
      n_errors++;
      end_sim();
    end
  end

  task automatic check(input logic [27:0] got, input logic [27:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmd(input logic [7:0] c);
    host_model_inst.put(1'b0, c);
  endtask

  task automatic dat(input logic [7:0] d);
    host_model_inst.put(1'b1, d);
  endtask

  task automatic settle();
    host_model_inst.idle();
    repeat (4) @(posedge clk_sys);
  endtask

  // both windows are always sent together with start below end
  task automatic win(input logic [7:0] c0, input logic [7:0] c1, input logic [7:0] p0, input logic [7:0] p1);
    cmd(8'h2A);
    dat(c0);
    dat(c1);
    cmd(8'h2B);
    dat(p0);
    dat(p1);
  endtask

  task automatic t_reset(input logic strap);
    #1;
    reset = 1'b1;
    ram_division_strap = strap;
    repeat (6) @(posedge clk_sys);
    #1 reset = 1'b0;
    repeat (3) @(posedge clk_sys);
    check(display_on, 0);
    check(segments_off, 1);
    check({start_column, end_column}, strap ? 16'h0061 : 16'h0067);
    check({start_page, end_page}, strap ? 16'h0042 : 16'h0053);
  endtask

  task automatic t_display();
    cmd(8'h29);
    settle();
    check({display_on, segments_off}, 2'h2);
    cmd(8'h28);
    settle();
    check({display_on, segments_off}, 2'h1);
  endtask

  // sink stalls while five words go in, so the buffer fills and the host waits
  task automatic t_write();
    pix_q.delete();
    #1 pixel_ready = 1'b0;
    win(8'h02, 8'h03, 8'h05, 8'h06);
    fork
      begin
        cmd(8'h2C);
        for (int i = 0; i < 5; i++) dat(8'h10 + 8'(i));
        cmd(8'h29);
        dat(8'h77);
      end
      begin
        repeat (12) @(posedge clk_sys);
        #1 pixel_ready = 1'b1;
      end
    join
    settle();
    check(pix_q.size(), 5);
    for (int i = 0; i < 5 && i < pix_q.size(); i++)
      check(pix_q[i], {8'(2 + i % 2), 8'(5 + i / 2), 12'(8'h10 + i)});
  endtask

  task automatic t_dir();
    pix_q.delete();
    cmd(8'h36);
    dat(8'h20);
    cmd(8'h2C);
    for (int i = 0; i < 3; i++) dat(8'h40);
    settle();
    check(page_direction, 1);
    check(pix_q.size(), 3);
    for (int i = 0; i < 3 && i < pix_q.size(); i++)
      check({pix_q[i].column, pix_q[i].page}, {8'(2 + i / 2), 8'(5 + i % 2)});
    cmd(8'h36);
    dat(8'h00);
  endtask

  // every entry is loaded, upper nibbles carry junk that must be ignored
  task automatic t_lut();
    pix_q.delete();
    cmd(8'h2D);
    for (int i = 0; i < 20; i++) begin
      lut[i] = 4'(i * 7 + 3);
      dat({4'hF - 4'(i), lut[i]});
    end
    #1 colour_256_mode = 1'b1;
    cmd(8'h2C);
    dat(8'hAE);
    dat(8'hFF);
    settle();
    #1 colour_256_mode = 1'b0;
    check(pix_q.size(), 2);
    if (pix_q.size() == 2) begin
      check(pix_q[0].colour, {lut[5], lut[11], lut[18]});
      check(pix_q[1].colour, {lut[7], lut[15], lut[19]});
    end
  endtask

  // with c0 of 8'h66 the window runs past the last ram column; out-of-range writes vanish
  task automatic t_read(input logic [7:0] c0, input logic [7:0] p0, input int n, input int n_in);
    pix_q.delete();
    rd_q.delete();
    win(c0, c0 + 8'h03, p0, p0 + 8'h01);
    cmd(8'h2C);
    for (int i = 0; i < 4; i++) dat(8'h01);
    cmd(8'h2E);
    for (int i = 0; i < 4; i++) dat(8'h00);
    cmd(8'h29);
    dat(8'h00);
    settle();
    check(pix_q.size(), n_in);
    check(rd_q.size(), 4);
    for (int i = 0; i < n && i < rd_q.size(); i++)
      check(rd_q[i], {i < n_in, c0 + 8'(i), p0});
  endtask

  initial begin
    reset = 1'b1;
    ram_division_strap = 1'b0;
    colour_256_mode = 1'b0;
    pixel_ready = 1'b1;
    t_reset(1'b1);
    t_reset(1'b0);
    t_display();
    t_write();
    t_dir();
    t_lut();
    t_read(8'h02, 8'h05, 4, 4);
    t_read(8'h66, 8'h00, 4, 2);
    end_sim();
  end
endmodule

bind lcd_ram_window_commands lcd_ram_window_commands_props lcd_ram_window_commands_props_inst (
  .clk_sys(clk_sys), .reset(reset), .host_byte(host_byte), .host_valid(host_valid), .host_ready(host_ready),
  .display_on(display_on), .segments_off(segments_off), .pixel_word(pixel_word), .pixel_valid(pixel_valid),
  .pixel_ready(pixel_ready), .read_column(read_column), .read_page(read_page), .read_request(read_request),
  .read_in_range(read_in_range), .start_column(start_column), .end_column(end_column), .start_page(start_page),
  .end_page(end_page), .page_direction(page_direction)
);
